// file: verilog/lpm_ctrl_end.sv
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl_end #(
   parameter int CK_HALF_CYC     = lpm_pkg::BOOT_CK_HALF_CYC,
   parameter int LOW_HOLD_CYC    = lpm_pkg::POST_RAMP_LOW_CYC,
   parameter int ENABLE_IDLE_CYC = lpm_pkg::POST_ENABLE_IDLE_CYC,
   parameter int RESET_WAIT_CYC  = lpm_pkg::POST_RESET_WAIT_CYC,
   parameter int AUTO_INIT_CYC   = lpm_pkg::AUTO_INIT_MAX_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic        supplyOk,
   lpm_link_if.ctrl         link
);
   localparam logic [lpm_pkg::CA_W-1:0] NOP_CA =
      lpm_pkg::packCa(lpm_pkg::CMD_NOP, 8'h00, 8'h00);

   typedef struct packed {
      lpm_pkg::lpm_cst_t         st;
      logic                      ck;
      logic [3:0]                half;
      logic [2:0]                ckRises;
      logic                      cke;
      logic                      csN;
      logic [lpm_pkg::CA_W-1:0]  ca;
      logic [15:0]               cnt;
      logic [15:0]               aiCnt;
      logic                      cmdPend;
      logic                      onBus;
      logic                      rdWait;
      logic                      oePrev;
      logic [lpm_pkg::CA_W-1:0]  cmdCa;
      logic [7:0]                lastRd;
      logic                      done;
      logic                      timeout;
      logic                      ack;
      logic [31:0]               rdat;
   } lpm_ctrl_state_t;

   lpm_ctrl_state_t r_r;
   lpm_ctrl_state_t r_nxt;
   logic [9:0]      pins;
   logic            supplyS;
   logic            oeS;
   logic [7:0]      dqS;
   logic            ckFall;
   logic            cmdIdle;
   logic            busy;

   lpm_sync #(.W(10), .RST(10'h000)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({supplyOk, link.dqOe, link.dq}),
      .q     (pins)
   );
   assign {supplyS, oeS, dqS} = pins;

   assign busy    = r_r.cmdPend || r_r.onBus || r_r.rdWait;
   assign cmdIdle = !busy && !oeS;

   always_comb begin
      r_nxt     = r_r;
      r_nxt.ack = 1'b0;
      ckFall    = 1'b0;

      // boot clock divider, free running
      if (r_r.half == 4'h0) begin
         r_nxt.half = 4'(CK_HALF_CYC - 1);
         r_nxt.ck   = !r_r.ck;
         ckFall     = r_r.ck;
         if (!r_r.ck && r_r.ckRises != 3'h5) begin
            r_nxt.ckRises = r_r.ckRises + 3'h1;
         end
      end else begin
         r_nxt.half = r_r.half - 4'h1;
      end

      if (r_r.cnt != 16'h0000) begin
         r_nxt.cnt = r_r.cnt - 16'h0001;
      end
      if (r_r.aiCnt != 16'h0000) begin
         r_nxt.aiCnt = r_r.aiCnt - 16'h0001;
      end

      // commands change on the falling edge, held one full period
      if (ckFall) begin
         if (r_r.cmdPend) begin
            r_nxt.csN     = 1'b0;
            r_nxt.ca      = r_r.cmdCa;
            r_nxt.cmdPend = 1'b0;
            r_nxt.onBus   = 1'b1;
            if (r_r.st == lpm_pkg::ST_RSTWAIT) begin
               r_nxt.cnt   = 16'(RESET_WAIT_CYC + CK_HALF_CYC);
               r_nxt.aiCnt = 16'(AUTO_INIT_CYC + CK_HALF_CYC);
            end
         end else begin
            r_nxt.csN   = 1'b1;
            r_nxt.ca    = NOP_CA;
            r_nxt.onBus = 1'b0;
         end
      end

      // read data capture on the first cycle the die drives
      r_nxt.oePrev = oeS;
      if (r_r.rdWait && oeS && !r_r.oePrev) begin
         r_nxt.lastRd = dqS;
         r_nxt.rdWait = 1'b0;
         if (r_r.st == lpm_pkg::ST_POLL) begin
            if (!dqS[lpm_pkg::DI_AUTO_INIT_BIT]) begin
               r_nxt.st   = lpm_pkg::ST_READY;
               r_nxt.done = 1'b1;
            end else if (r_r.aiCnt == 16'h0000) begin
               r_nxt.st      = lpm_pkg::ST_READY;
               r_nxt.timeout = 1'b1;
            end
         end
      end

      case (r_r.st)
         lpm_pkg::ST_IDLE: begin
            r_nxt.cke = 1'b0;
         end
         lpm_pkg::ST_RAMP: begin
            r_nxt.cke = 1'b0;
            if (supplyS) begin
               r_nxt.st  = lpm_pkg::ST_LOWHOLD;
               r_nxt.cnt = 16'(LOW_HOLD_CYC);
            end
         end
         lpm_pkg::ST_LOWHOLD: begin
            if (!supplyS) begin
               r_nxt.st = lpm_pkg::ST_RAMP;
            end else if (r_r.cnt == 16'h0000 &&
                         r_r.ckRises == 3'h5) begin
               r_nxt.st  = lpm_pkg::ST_ENIDLE;
               r_nxt.cke = 1'b1;
               r_nxt.cnt = 16'(ENABLE_IDLE_CYC);
            end
         end
         lpm_pkg::ST_ENIDLE: begin
            if (r_r.cnt == 16'h0000) begin
               r_nxt.st      = lpm_pkg::ST_RSTWAIT;
               r_nxt.cmdPend = 1'b1;
               r_nxt.cmdCa   = lpm_pkg::packCa(lpm_pkg::CMD_MRW,
                                  lpm_pkg::MA_SOFT_RESET, 8'h00);
            end
         end
         lpm_pkg::ST_RSTWAIT: begin
            if (cmdIdle && r_r.cnt == 16'h0000) begin
               r_nxt.st = lpm_pkg::ST_POLL;
            end
         end
         lpm_pkg::ST_POLL: begin
            if (cmdIdle) begin
               r_nxt.cmdPend = 1'b1;
               r_nxt.rdWait  = 1'b1;
               r_nxt.cmdCa   = lpm_pkg::packCa(lpm_pkg::CMD_MRR,
                                  lpm_pkg::MA_DEVICE_INFO, 8'h00);
            end
         end
         lpm_pkg::ST_READY: ;
         default: r_nxt.st = lpm_pkg::ST_IDLE;
      endcase

      // register slave, answer one cycle after the request
      if (cyc_i && stb_i && !r_r.ack) begin
         r_nxt.ack  = 1'b1;
         r_nxt.rdat = 32'h0000_0000;
         case (adr_i)
            lpm_pkg::WB_CTRL: begin
               if (we_i && sel_i[0] && dat_i[lpm_pkg::CTRL_START_BIT]) begin
                  r_nxt.st      = lpm_pkg::ST_RAMP;
                  r_nxt.cke     = 1'b0;
                  r_nxt.csN     = 1'b1;
                  r_nxt.ca      = NOP_CA;
                  r_nxt.cmdPend = 1'b0;
                  r_nxt.onBus   = 1'b0;
                  r_nxt.rdWait  = 1'b0;
                  r_nxt.done    = 1'b0;
                  r_nxt.timeout = 1'b0;
               end
            end
            lpm_pkg::WB_CMD: begin
               if (!we_i) begin
                  r_nxt.rdat = 32'(r_r.cmdCa);
               end else if (sel_i[2:0] == 3'h7 && cmdIdle &&
                            r_r.st == lpm_pkg::ST_READY) begin
                  r_nxt.cmdPend = 1'b1;
                  r_nxt.rdWait  = !dat_i[lpm_pkg::CMD_WRITE_BIT];
                  r_nxt.cmdCa   = lpm_pkg::packCa(
                     dat_i[lpm_pkg::CMD_WRITE_BIT] ? lpm_pkg::CMD_MRW
                                                   : lpm_pkg::CMD_MRR,
                     dat_i[7:0], dat_i[15:8]);
               end
            end
            lpm_pkg::WB_STATUS: begin
               r_nxt.rdat = {16'h0000, r_r.lastRd, 1'b0, r_r.cke, busy,
                             r_r.timeout, r_r.done, r_r.st};
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r <= '{st: lpm_pkg::ST_IDLE, ck: 1'b0, half: 4'h0,
                  ckRises: 3'h0, cke: 1'b0, csN: 1'b1, ca: NOP_CA,
                  cnt: 16'h0000, aiCnt: 16'h0000, cmdPend: 1'b0,
                  onBus: 1'b0, rdWait: 1'b0, oePrev: 1'b0,
                  cmdCa: NOP_CA, lastRd: 8'h00, done: 1'b0,
                  timeout: 1'b0, ack: 1'b0, rdat: 32'h0000_0000};
      end else begin
         r_r <= r_nxt;
      end
   end

   assign link.ck  = r_r.ck;
   assign link.cke = r_r.cke;
   assign link.csN = r_r.csN;
   assign link.ca  = r_r.ca;
   assign dat_o    = r_r.rdat;
   assign ack_o    = r_r.ack;
endmodule
`default_nettype wire

// file: verilog/lpm_pkg.sv
`default_nettype none
package lpm_pkg;
   // timing figures and their cycle counts at the 50 ns system clock
   localparam int CLK_PERIOD_NS            = 50;
   localparam int POST_RAMP_LOW_TIME_NS    = 100;
   localparam int PRE_ENABLE_CLOCK_TIME    = 5;
   localparam int POST_ENABLE_IDLE_TIME_US = 200;
   localparam int POST_RESET_WAIT_US       = 1;
   localparam int AUTO_INIT_MAX_TIME_US    = 10;
   localparam int BOOT_CYCLE_TIME_MAX_NS   = 100;
   localparam int POST_RAMP_LOW_CYC =
      (POST_RAMP_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POST_ENABLE_IDLE_CYC =
      (POST_ENABLE_IDLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POST_RESET_WAIT_CYC =
      (POST_RESET_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int AUTO_INIT_MAX_CYC =
      AUTO_INIT_MAX_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int BOOT_CK_HALF_CYC =
      BOOT_CYCLE_TIME_MAX_NS / (2 * CLK_PERIOD_NS);
   localparam int DIE_AUTO_INIT_CYC = 40;
   localparam int RD_HOLD_CYC       = 4;

   // command/address word: {op, ma, cmd}
   localparam int CA_W      = 20;
   localparam int CA_MA_LSB = 4;
   localparam int CA_OP_LSB = 12;
   typedef enum logic [3:0] {
      CMD_MRW = 4'h0,
      CMD_MRR = 4'h1,
      CMD_NOP = 4'h7
   } lpm_cmd_t;

   // mode register addresses
   localparam logic [7:0] MA_DEVICE_INFO      = 8'h00;
   localparam logic [7:0] MA_BURST_WR_CFG     = 8'h01;
   localparam logic [7:0] MA_LATENCY_CFG      = 8'h02;
   localparam logic [7:0] MA_OUTPUT_DRIVE_CFG = 8'h03;
   localparam logic [7:0] MA_REFRESH_RATE     = 8'h04;
   localparam logic [7:0] MA_MAKER_CODE       = 8'h05;
   localparam logic [7:0] MA_DIE_REV_PRIMARY  = 8'h06;
   localparam logic [7:0] MA_DIE_REV_SECOND   = 8'h07;
   localparam logic [7:0] MA_GEOMETRY_INFO    = 8'h08;
   localparam logic [7:0] MA_VENDOR_TEST_MODE = 8'h09;
   localparam logic [7:0] MA_IMPEDANCE_CAL    = 8'h0a;
   localparam logic [7:0] MA_PR_BANK_MASK     = 8'h10;
   localparam logic [7:0] MA_PR_SEGMENT_MASK  = 8'h11;
   localparam logic [7:0] MA_TRAINING_A       = 8'h20;
   localparam logic [7:0] MA_TRAINING_B       = 8'h28;
   localparam logic [7:0] MA_SOFT_RESET       = 8'h3f;

   // mode register reset values and identity defaults
   localparam logic [7:0] BURST_WR_CFG_RST  = 8'h22;
   localparam logic [7:0] LATENCY_CFG_RST   = 8'h01;
   localparam logic [7:0] DRIVE_CFG_RST     = 8'h02;
   localparam logic [7:0] REFRESH_RATE_RST  = 8'h03;
   localparam logic [7:0] VENDOR_TEST_RST   = 8'h10;
   localparam logic [7:0] MAKER_CODE_DEF    = 8'h5a; // arbitrary value
   localparam logic [7:0] DIE_REV1_DEF      = 8'h01; // arbitrary value
   localparam logic [7:0] DIE_REV2_DEF      = 8'h00; // arbitrary value
   localparam logic [7:0] GEOMETRY_DEF      = 8'h14;
   localparam logic [7:0] TRAINING_A_DEF    = 8'h00;
   localparam logic [7:0] TRAINING_B_DEF    = 8'h00;
   localparam int         DI_AUTO_INIT_BIT  = 0;
   localparam int         DI_DEVICE_KIND_BIT = 1;
   localparam logic [7:0] VTM_FAIL_MASK     = 8'h20;

   // controller register map (byte addresses)
   localparam logic [7:0] WB_CTRL   = 8'h00;
   localparam logic [7:0] WB_CMD    = 8'h04;
   localparam logic [7:0] WB_STATUS = 8'h08;
   localparam int CTRL_START_BIT = 0;
   localparam int CMD_WRITE_BIT  = 16;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_RAMP    = 3'b001,
      ST_LOWHOLD = 3'b011,
      ST_ENIDLE  = 3'b010,
      ST_RSTWAIT = 3'b110,
      ST_POLL    = 3'b111,
      ST_READY   = 3'b101
   } lpm_cst_t;

   function automatic logic [CA_W-1:0] packCa(lpm_cmd_t c,
                                              logic [7:0] ma,
                                              logic [7:0] op);
      return {op, ma, c};
   endfunction
endpackage
`default_nettype wire

// file: verilog/lpm_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lpm_link_if;
   logic                      ck;
   logic                      cke;
   logic                      csN;
   logic [lpm_pkg::CA_W-1:0]  ca;
   logic [7:0]                dq;
   logic                      dqOe;
   modport ctrl (output ck, cke, csN, ca, input dq, dqOe);
   modport dram (input ck, cke, csN, ca, output dq, dqOe);
endinterface
`default_nettype wire

// file: verilog/lpm_sync.sv
`timescale 1ns/100ps
`default_nettype none
module lpm_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } lpm_sync_t;
   lpm_sync_t r_r;
   lpm_sync_t r_nxt;

   // a bit moves only once stages two and three agree
   always_comb begin
      r_nxt    = r_r;
      r_nxt.s1 = d;
      r_nxt.s2 = r_r.s1;
      r_nxt.s3 = r_r.s2;
      r_nxt.q  = (r_r.s2 & r_r.s3) | (r_r.q & (r_r.s2 | r_r.s3));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r <= '{s1: RST, s2: RST, s3: RST, q: RST};
      end else begin
         r_r <= r_nxt;
      end
   end

   assign q = r_r.q;
endmodule
`default_nettype wire

// file: verilog/lpm_dram_end.sv
`timescale 1ns/100ps
`default_nettype none
module lpm_dram_end #(
   parameter int         AUTO_INIT_CYC = lpm_pkg::DIE_AUTO_INIT_CYC,
   parameter int         RD_HOLD_CYC   = lpm_pkg::RD_HOLD_CYC,
   parameter logic [7:0] MAKER_CODE    = lpm_pkg::MAKER_CODE_DEF,
   parameter logic [7:0] DIE_REV1      = lpm_pkg::DIE_REV1_DEF,
   parameter logic [7:0] DIE_REV2      = lpm_pkg::DIE_REV2_DEF,
   parameter logic [7:0] GEOMETRY      = lpm_pkg::GEOMETRY_DEF,
   parameter logic [7:0] TRAINING_A    = lpm_pkg::TRAINING_A_DEF,
   parameter logic [7:0] TRAINING_B    = lpm_pkg::TRAINING_B_DEF
) (
   input  wire logic clk,
   input  wire logic rst_n,
   lpm_link_if.dram  link,
   output logic       initDone,
   output logic [7:0] cfgBurst,
   output logic [7:0] cfgLatency,
   output logic [7:0] cfgDrive,
   output logic [7:0] cfgRefresh
);
   localparam int SW = lpm_pkg::CA_W + 3;
   typedef struct packed {
      logic       ckPrev;
      logic       busy;
      logic [7:0] cnt;
      logic [3:0] rdCnt;
      logic [7:0] rdData;
      logic [7:0] mr1;
      logic [7:0] mr2;
      logic [7:0] mr3;
      logic [7:0] mr4;
      logic [7:0] mr9;
      logic [7:0] impedance_calibration_cmd;
      logic [7:0] partial_refresh_bank_mask;
      logic [7:0] partial_refresh_segment_mask;
   } lpm_dram_state_t;
   localparam lpm_dram_state_t DRAM_RST = '{
      ckPrev: 1'b0, busy: 1'b1, cnt: 8'h00, rdCnt: 4'h0, rdData: 8'h00,
      mr1: lpm_pkg::BURST_WR_CFG_RST, mr2: lpm_pkg::LATENCY_CFG_RST,
      mr3: lpm_pkg::DRIVE_CFG_RST, mr4: lpm_pkg::REFRESH_RATE_RST,
      mr9: lpm_pkg::VENDOR_TEST_RST, impedance_calibration_cmd: 8'h00, partial_refresh_bank_mask: 8'h00,
      partial_refresh_segment_mask: 8'h00};

   lpm_dram_state_t r_r;
   lpm_dram_state_t r_nxt;
   logic [SW-1:0]   pins;
   logic            ckS;
   logic            ckeS;
   logic            csNS;
   logic [lpm_pkg::CA_W-1:0] caS;
   logic [7:0]      ma;
   logic [7:0]      op;
   logic            take;

   lpm_sync #(.W(SW), .RST({3'b001, {lpm_pkg::CA_W{1'b0}}})) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({link.ck, link.cke, link.csN, link.ca}),
      .q     (pins)
   );
   assign {ckS, ckeS, csNS, caS} = pins;
   assign ma   = caS[lpm_pkg::CA_MA_LSB +: 8];
   assign op   = caS[lpm_pkg::CA_OP_LSB +: 8];
   assign take = ckS && !r_r.ckPrev && ckeS && !csNS;

   always_comb begin
      r_nxt        = r_r;
      r_nxt.ckPrev = ckS;
      if (r_r.rdCnt != 4'h0) begin
         r_nxt.rdCnt = r_r.rdCnt - 4'h1;
      end
      if (r_r.cnt != 8'h00) begin
         r_nxt.cnt = r_r.cnt - 8'h01;
         if (r_r.cnt == 8'h01) begin
            r_nxt.busy = 1'b0;
         end
      end
      if (take && caS[3:0] == lpm_pkg::CMD_MRW) begin
         if (ma == lpm_pkg::MA_SOFT_RESET) begin
            r_nxt      = DRAM_RST;
            r_nxt.cnt  = 8'(AUTO_INIT_CYC);
            r_nxt.ckPrev = ckS;
         end else if (!r_r.busy) begin
            case (ma)
               lpm_pkg::MA_BURST_WR_CFG:     r_nxt.mr1 = op;
               lpm_pkg::MA_LATENCY_CFG:      r_nxt.mr2 = op;
               lpm_pkg::MA_OUTPUT_DRIVE_CFG: r_nxt.mr3 = op;
               lpm_pkg::MA_REFRESH_RATE:     r_nxt.mr4 = op;
               lpm_pkg::MA_VENDOR_TEST_MODE: begin
                  r_nxt.mr9 = (op & ~lpm_pkg::VTM_FAIL_MASK) |
                              (r_r.mr9 & lpm_pkg::VTM_FAIL_MASK);
               end
               lpm_pkg::MA_IMPEDANCE_CAL:    r_nxt.impedance_calibration_cmd = op;
               lpm_pkg::MA_PR_BANK_MASK:     r_nxt.partial_refresh_bank_mask = op;
               lpm_pkg::MA_PR_SEGMENT_MASK:  r_nxt.partial_refresh_segment_mask = op;
               default: ;
            endcase
         end
      end
      if (take && caS[3:0] == lpm_pkg::CMD_MRR) begin
         r_nxt.rdCnt = 4'(RD_HOLD_CYC);
         case (ma)
            lpm_pkg::MA_DEVICE_INFO: begin
               r_nxt.rdData = 8'h00;
               r_nxt.rdData[lpm_pkg::DI_AUTO_INIT_BIT]   = r_r.busy;
               r_nxt.rdData[lpm_pkg::DI_DEVICE_KIND_BIT] = 1'b0;
            end
            lpm_pkg::MA_MAKER_CODE:       r_nxt.rdData = MAKER_CODE;
            lpm_pkg::MA_DIE_REV_PRIMARY:  r_nxt.rdData = DIE_REV1;
            lpm_pkg::MA_DIE_REV_SECOND:   r_nxt.rdData = DIE_REV2;
            lpm_pkg::MA_GEOMETRY_INFO:    r_nxt.rdData = GEOMETRY;
            lpm_pkg::MA_VENDOR_TEST_MODE: r_nxt.rdData = r_r.mr9;
            lpm_pkg::MA_TRAINING_A:       r_nxt.rdData = TRAINING_A;
            lpm_pkg::MA_TRAINING_B:       r_nxt.rdData = TRAINING_B;
            default: r_nxt.rdData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r <= DRAM_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign link.dq    = r_r.rdData;
   assign link.dqOe  = (r_r.rdCnt != 4'h0) && ckeS;
   assign initDone   = !r_r.busy;
   assign cfgBurst   = r_r.mr1;
   assign cfgLatency = r_r.mr2;
   assign cfgDrive   = r_r.mr3;
   assign cfgRefresh = r_r.mr4;
endmodule
`default_nettype wire

// file: tb/lpm_link_chk.sv
`timescale 1ns/100ps
`default_nettype none
module lpm_link_chk #(
   parameter int IDLE_CYC = 50,
   parameter int WAIT_CYC = 20
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     ck,
   input  wire logic                     cke,
   input  wire logic                     csN,
   input  wire logic [lpm_pkg::CA_W-1:0] ca,
   input  wire logic [7:0]               dq,
   input  wire logic                     dqOe
);
   typedef struct packed {
      logic [15:0] lowCnt;
      logic [15:0] hiCnt;
      logic [15:0] rstCnt;
      logic        sawRst;
      logic        done;
      logic [7:0]  lastMa;
   } lpm_chk_st_t;
   lpm_chk_st_t st_r;
   lpm_chk_st_t st_nxt;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   always_comb begin
      st_nxt = st_r;
      st_nxt.lowCnt = cke ? 16'h0000 : st_r.lowCnt + 16'h0001;
      st_nxt.hiCnt = cke ? st_r.hiCnt + 16'h0001 : 16'h0000;
      st_nxt.rstCnt = st_r.rstCnt + 16'h0001;
      if (!csN) begin
         st_nxt.lastMa = ca[11:4];
      end
      if (cke && !csN && !st_r.sawRst) begin
         st_nxt.sawRst = 1'b1;
         st_nxt.rstCnt = 16'h0000;
      end
      if (dqOe && st_r.lastMa == 8'h00 && !dq[0]) begin
         st_nxt.done = 1'b1;
      end
      if (!cke) begin
         st_nxt.sawRst = 1'b0;
         st_nxt.done = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   sequence readBurst;
      dqOe[*4] ##1 !dqOe;
   endsequence
   chk_oe_cke: assert property (
      (!cke)[*4] |-> !dqOe) else $error("data driven while enable low");
   chk_cmd_cke: assert property (
      !csN |-> cke) else $error("command while enable low");
   chk_ck_half: assert property (
      $changed(ck) |=> $stable(ck)[*3]) else $error("link clock uneven");
   chk_low_hold: assert property (
      $rose(cke) |-> st_r.lowCnt >= 16'h0028) else $error("enable rose early");
   chk_reset_first: assert property (
      (!csN && !st_r.sawRst) |-> (ca[11:0] == 12'h3f0
      && st_r.hiCnt >= IDLE_CYC)) else $error("first command wrong");
   chk_rst_quiet: assert property (
      ($fell(csN) && st_r.sawRst) |-> st_r.rstCnt >= WAIT_CYC)
      else $error("command too soon after reset");
   chk_poll_reads: assert property (
      (!csN && st_r.sawRst && !st_r.done && st_r.rstCnt >= WAIT_CYC)
      |-> ca[11:0] == 12'h001) else $error("non-poll command in init");
   chk_dai_bound: assert property (
      (dqOe && st_r.sawRst && st_r.lastMa == 8'h00
      && st_r.rstCnt >= 16'h00c8) |-> !dq[0]) else $error("init too long");
   chk_info_kind: assert property (
      (dqOe && st_r.lastMa == 8'h00) |-> !dq[1]) else $error("kind bit set");
   chk_read_len: assert property (
      $rose(dqOe) |-> readBurst) else $error("read data length");
endmodule
`default_nettype wire

// file: tb/lpddr2_powerup_mode_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lpddr2_powerup_mode_regs_tb;
   localparam int LIMIT = 30000;
   logic        clk;
   logic        rst_n;
   logic        cyc;
   logic        stb;
   logic        we;
   logic        ack;
   logic        supplyOk;
   logic        initDone;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] datW;
   logic [31:0] datR;
   logic [31:0] rd;
   logic [7:0]  cfgB;
   logic [7:0]  cfgL;
   logic [7:0]  cfgD;
   logic [7:0]  cfgR;
   logic [7:0]  mdl [256];
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cycles = 0;
   lpm_link_if link ();
   lpm_ctrl_end #(.CK_HALF_CYC(4), .ENABLE_IDLE_CYC(50), .RESET_WAIT_CYC(20),
      .AUTO_INIT_CYC(200)) i_lpm_ctrl_end (.clk(clk), .rst_n(rst_n),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(datW),
      .sel_i(sel), .dat_o(datR), .ack_o(ack), .supplyOk(supplyOk),
      .link(link.ctrl));
   lpm_dram_end i_lpm_dram_end (.clk(clk),
      .rst_n(rst_n), .link(link.dram), .initDone(initDone), .cfgBurst(cfgB),
      .cfgLatency(cfgL), .cfgDrive(cfgD), .cfgRefresh(cfgR));
   lpm_link_chk i_lpm_link_chk (.clk(clk),
      .rst_n(rst_n), .ck(link.ck), .cke(link.cke), .csN(link.csN),
      .ca(link.ca), .dq(link.dq), .dqOe(link.dqOe));
   initial clk = 1'b0;
   always #25 clk = ~clk;
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic cmpWord(input logic [31:0] g, e, input string s);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, s, g, e);
      end
   endtask
   task automatic cmpByte(input logic [7:0] g, e, input string s);
      cmpWord({24'h0, g}, {24'h0, e}, s);
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datW <= d;
      // ends on ack; no timeout of its own, the bench timeout ends a wait that never sees ack
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic waitFor(input logic [7:0] m, v);
      do begin
         wb(1'b0, lpm_pkg::WB_STATUS, 32'h0);
      end while ((rd[7:0] & m) !== v);
   endtask
   function automatic logic [7:0] expRd(input logic [7:0] a);
      if (a inside {8'h00, [8'h05:8'h09], 8'h20, 8'h28}) begin
         return mdl[a];
      end
      return 8'h00;
   endfunction
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      logic [7:0] tbl [24];
      logic [7:0] ma;
      logic [7:0] op;
      tbl = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
         8'h09, 8'h0a, 8'h10, 8'h11, 8'h20, 8'h28, 8'h0b, 8'h0f, 8'h12, 8'h17,
         8'h18, 8'h27, 8'h3e, 8'h40, 8'hff};
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'hf;
      datW = 32'h0;
      supplyOk = 1'b0;
      void'($urandom(32'ha8d3));
      foreach (mdl[i]) mdl[i] = 8'h00;
      mdl[1] = lpm_pkg::BURST_WR_CFG_RST;
      mdl[2] = lpm_pkg::LATENCY_CFG_RST;
      mdl[3] = lpm_pkg::DRIVE_CFG_RST;
      mdl[4] = lpm_pkg::REFRESH_RATE_RST;
      mdl[5] = lpm_pkg::MAKER_CODE_DEF;
      mdl[6] = lpm_pkg::DIE_REV1_DEF;
      mdl[7] = lpm_pkg::DIE_REV2_DEF;
      mdl[8] = lpm_pkg::GEOMETRY_DEF;
      mdl[9] = lpm_pkg::VENDOR_TEST_RST;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      wb(1'b0, lpm_pkg::WB_STATUS, 32'h0);
      cmpWord(rd, 32'h0, "idle status");
      wb(1'b0, 8'h0c, 32'h0);
      cmpWord(rd, 32'h0, "unmapped read");
      $display("test reset done");
      wb(1'b1, lpm_pkg::WB_CTRL, 32'h1);
      wb(1'b1, lpm_pkg::WB_CMD, 32'h00015502);
      wb(1'b0, lpm_pkg::WB_CMD, 32'h0);
      cmpWord(rd, 32'h00000007, "cmd before ready");
      repeat (30) @(posedge clk);
      wb(1'b0, lpm_pkg::WB_STATUS, 32'h0);
      cmpByte({4'h0, rd[6], rd[2:0]}, 8'h01, "ramp hold");
      supplyOk <= 1'b1;
      waitFor(8'h07, 8'h05);
      cmpWord(rd, 32'h0000004d, "init status");
      cmpByte({7'h0, initDone}, 8'h01, "die ready");
      cmpWord({cfgB, cfgL, cfgD, cfgR}, 32'h22010203, "defaults");
      // partial byte select must leave the command untouched
      sel <= 4'h1;
      wb(1'b1, lpm_pkg::WB_CMD, 32'h0001aa01);
      wb(1'b0, lpm_pkg::WB_CMD, 32'h0);
      sel <= 4'hf;
      cmpWord(rd, 32'h00000001, "cmd sel refused");
      repeat (40) @(posedge clk);
      cmpWord({cfgB, cfgL, cfgD, cfgR}, 32'h22010203, "no write");
      $display("test init done");
      for (int i = 0; i < 48; i++) begin
         ma = (i < 24) ? tbl[i] : tbl[$urandom_range(23)];
         op = 8'($urandom);
         wb(1'b1, lpm_pkg::WB_CMD, {15'h0, 1'b1, op, ma});
         waitFor(8'h20, 8'h00);
         if (ma inside {[8'h01:8'h04]}) begin
            mdl[ma] = op;
         end
         if (ma == 8'h09) begin
            mdl[9] = (op & ~lpm_pkg::VTM_FAIL_MASK)
               | (mdl[9] & lpm_pkg::VTM_FAIL_MASK);
         end
         wb(1'b1, lpm_pkg::WB_CMD, {24'h0, ma});
         waitFor(8'h20, 8'h00);
         cmpByte(rd[15:8], expRd(ma), "mode read");
         cmpWord({cfgB, cfgL, cfgD, cfgR}, {mdl[1], mdl[2], mdl[3], mdl[4]},
            "config");
      end
      $display("test mode registers done");
      complete_run();
   end
endmodule
`default_nettype wire
